// *** rtl/smc_defs.vh ***
// Timing counts, state codes and field limits of the mode state controller.
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

`define SMC_CLK_HZ          40000000
`define SMC_TICK_US         1000
`define SMC_TICK_CYCLES     ((`SMC_CLK_HZ / 1000000) * `SMC_TICK_US)

`define SMC_RST_MS          16'h0001
`define SMC_LONG_RST_MS     16'h000a
`define SMC_CFG_TMO_MS      16'h0100
`define SMC_NREQ_TMO_MS     16'h0100
`define SMC_FLASH_WD_MS     16'h7d00
`define SMC_OC_MAX_MS       16'h0020

`define SMC_ST_INIT_RST     8'h01
`define SMC_ST_INIT         8'h02
`define SMC_ST_RESET        8'h04
`define SMC_ST_NREQ         8'h08
`define SMC_ST_NORMAL       8'h10
`define SMC_ST_FLASH        8'h20
`define SMC_ST_LP_ON        8'h40
`define SMC_ST_LP_OFF       8'h80

`define SMC_SEC_INIT        2'h0
`define SMC_SEC_FLASH       2'h1
`define SMC_SEC_RESET       2'h2

`define SMC_LFSR_SEED       8'h5b
`define SMC_LFSR_TAPS       8'hb8

`endif

// *** rtl/smc_tick.v ***
// Free-running prescaler that yields the common time base tick.
`timescale 1ns/1ps
module smc_tick #(
  parameter TICK_CYCLES = 40000
) (
  input  wire clk_sys_in,
  input  wire rst_in,
  output reg  tick_out
);
  reg [31:0] cnt_reg;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_reg == TICK_CYCLES - 1) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule

// *** rtl/smc_mode_ctrl.v ***
// Operating-mode state machine of the system basis chip controller.
// Functional notes
// - Power-on: init reset, 1 ms low, supply-loss flag.
// - Missed config command returns to init reset.
// - Config follows init reset; 256 ms limit.
// - Init registers writable only in config.
// - Refresh leaves config; else init reset again.
// - Config re-entry only by secured command.
// - Config disables functions; supply on only debugging.
// - Watchdog failure or low supply enters reset.
// - Reset 1 ms; longer only after low supply.
// - Normal-request after reset or low-power wake.
// - Normal-request timeout resets; refresh goes normal.
// - Pass transistor enabled only normal and flash.
// - Normal mode needs periodic correct refresh.
// - Plain low-power entry; secured reset, config, flash.
// - Flash: 32 s watchdog, half-period interrupt.
// - Debug suppresses every watchdog timeout.
// - Debug ends on level loss or command.
// - Low power refused while wake flags set.
// - Supply-off mode wakes through reset, flags source.
// - Supply-on mode also wakes by command, overcurrent.
// - Overcurrent longer than selected time wakes.
// - Supply-on watchdog refreshed; wakes pulse interrupt.
// - Interrupt low level or timed pulse.
// - Fixed refresh word moves to normal.
// - Secured action needs inverted random code.
`timescale 1ns/1ps
`include "smc_defs.vh"
module smc_mode_ctrl #(
  parameter TICK_CYCLES = `SMC_TICK_CYCLES
) (
  input  wire       clk_sys_in,
  input  wire       rst_in,
  input  wire       debug_level_input_in,
  input  wire       vdd_low_in,
  input  wire       sleep_current_in,
  input  wire [4:0] wake_src_in,
  input  wire       wd_refresh_in,
  input  wire       wd_bad_in,
  input  wire       wd_window_in,
  input  wire [1:0] wd_period_sel_in,
  input  wire       init_wr_in,
  input  wire       lp_off_req_in,
  input  wire       lp_on_req_in,
  input  wire       nreq_wake_cmd_in,
  input  wire       lp_wd_refresh_in,
  input  wire       lp_wd_en_in,
  input  wire       flash_exit_in,
  input  wire       sec_req_in,
  input  wire [1:0] sec_target_in,
  input  wire       sec_confirm_in,
  input  wire [7:0] sec_code_in,
  input  wire       debug_exit_in,
  input  wire       long_rst_sel_in,
  input  wire [1:0] nreq_short_sel_in,
  input  wire [1:0] oc_time_sel_in,
  input  wire       can5v_ctl_in,
  input  wire [1:0] int_en_in,
  input  wire       int_pulse_sel_in,
  input  wire [1:0] int_width_sel_in,
  input  wire       int_clr_in,
  input  wire       wake_flag_clr_in,
  input  wire       supply_loss_clr_in,
  output wire [7:0] mode_out,
  output reg        rst_n_out,
  output reg        int_n_out,
  output wire       init_wr_accept_out,
  output reg        vdd_en_out,
  output reg        vdd_pnp_en_out,
  output reg        can5v_en_out,
  output reg        func_en_out,
  output reg        debug_active_out,
  output reg        supply_loss_flag_out,
  output reg  [4:0] wake_flags_out,
  output reg  [7:0] random_code_out
);
  localparam ST_INIT_RST = `SMC_ST_INIT_RST;
  localparam ST_INIT     = `SMC_ST_INIT;
  localparam ST_RESET    = `SMC_ST_RESET;
  localparam ST_NREQ     = `SMC_ST_NREQ;
  localparam ST_NORMAL   = `SMC_ST_NORMAL;
  localparam ST_FLASH    = `SMC_ST_FLASH;
  localparam ST_LP_ON    = `SMC_ST_LP_ON;
  localparam ST_LP_OFF   = `SMC_ST_LP_OFF;

  // Normal watchdog period in ticks, shared by normal and supply-on modes.
  function [15:0] wd_period;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    wd_period = 16'h000a;
        2'h1:    wd_period = 16'h002d;
        2'h2:    wd_period = 16'h0064;
        default: wd_period = 16'h015e;
      endcase
    end
  endfunction

  wire       tick;
  wire [7:0] raw_in;
  reg  [7:0] sync1_reg;
  reg  [7:0] sync2_reg;
  reg  [7:0] state_reg;
  reg  [7:0] state_next;
  reg [15:0] tmr_reg;
  reg [15:0] rst_len_reg;
  reg [15:0] rst_len_next;
  reg [15:0] nreq_len_reg;
  reg [15:0] nreq_len_next;
  reg [15:0] oc_cnt_reg;
  reg [15:0] int_cnt_reg;
  reg        refresh;
  reg        lp_wake;
  reg        dbg_next;
  reg        sec_pend_reg;
  reg  [1:0] sec_tgt_reg;
  reg  [7:0] lfsr_reg;
  reg        int_lvl_reg;
  reg        oc_prev_reg;

  wire       dbg_lvl   = sync2_reg[7];
  wire       vdd_low   = sync2_reg[6];
  wire       oc_high   = sync2_reg[5];
  wire [4:0] wake_sync = sync2_reg[4:0];
  wire       st_chg    = (state_next != state_reg);
  wire [15:0] wd_per   = wd_period(wd_period_sel_in);
  wire [15:0] oc_limit = `SMC_OC_MAX_MS >> (2'h3 - oc_time_sel_in);
  wire       sec_ok    = sec_pend_reg && sec_confirm_in && (sec_code_in == ~random_code_out);
  wire       flags_set = |wake_flags_out;
  wire       oc_wake   = oc_high && (oc_cnt_reg >= oc_limit);
  wire       oc_brief  = oc_prev_reg && !oc_high && (oc_cnt_reg < oc_limit);
  wire       flash_half = tick && (state_reg == ST_FLASH)
                          && (tmr_reg == (`SMC_FLASH_WD_MS >> 1));
  wire       int_event = (flash_half && int_en_in[0]) || (lp_wake && int_en_in[1]);

  assign raw_in = {debug_level_input_in, vdd_low_in, sleep_current_in, wake_src_in};
  assign mode_out = state_reg;
  assign init_wr_accept_out = init_wr_in && (state_reg == ST_INIT);

  smc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tick_out   (tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys_in) begin
        if (rst_in) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // Commands not listed for the current state fall through untouched.
  always @* begin
    state_next    = state_reg;
    rst_len_next  = rst_len_reg;
    nreq_len_next = nreq_len_reg;
    refresh       = 1'b0;
    lp_wake       = 1'b0;
    case (state_reg)
      ST_INIT_RST: begin
        if (tmr_reg >= `SMC_RST_MS)
          state_next = ST_INIT;
      end
      ST_INIT: begin
        if (wd_refresh_in)
          state_next = ST_NORMAL;
        else if (!debug_active_out && tmr_reg >= `SMC_CFG_TMO_MS)
          state_next = ST_INIT_RST;
      end
      ST_RESET: begin
        if (tmr_reg >= rst_len_reg) begin
          state_next    = ST_NREQ;
          nreq_len_next = `SMC_NREQ_TMO_MS;
        end
      end
      ST_NREQ: begin
        if (vdd_low) begin
          state_next   = ST_RESET;
          rst_len_next = long_rst_sel_in ? `SMC_LONG_RST_MS : `SMC_RST_MS;
        end else if (wd_refresh_in)
          state_next = ST_NORMAL;
        else if (!debug_active_out && tmr_reg >= nreq_len_reg) begin
          state_next   = ST_RESET;
          rst_len_next = `SMC_RST_MS;
        end
      end
      ST_NORMAL: begin
        if (vdd_low) begin
          state_next   = ST_RESET;
          rst_len_next = long_rst_sel_in ? `SMC_LONG_RST_MS : `SMC_RST_MS;
        end else if (!debug_active_out && (wd_bad_in || tmr_reg >= wd_per
                     || (wd_window_in && wd_refresh_in && tmr_reg < (wd_per >> 1)))) begin
          state_next   = ST_RESET;
          rst_len_next = `SMC_RST_MS;
        end else if (wd_refresh_in)
          refresh = 1'b1;
        else if (sec_ok) begin
          rst_len_next = `SMC_RST_MS;
          case (sec_tgt_reg)
            `SMC_SEC_INIT:  state_next = ST_INIT;
            `SMC_SEC_FLASH: state_next = ST_FLASH;
            `SMC_SEC_RESET: state_next = ST_RESET;
            default:        state_next = state_reg;
          endcase
        end else if (lp_off_req_in && !flags_set)
          state_next = ST_LP_OFF;
        else if (lp_on_req_in && !flags_set)
          state_next = ST_LP_ON;
      end
      ST_FLASH: begin
        rst_len_next = `SMC_RST_MS;
        if (vdd_low) begin
          state_next   = ST_RESET;
          rst_len_next = long_rst_sel_in ? `SMC_LONG_RST_MS : `SMC_RST_MS;
        end else if (!debug_active_out && (wd_bad_in || tmr_reg >= `SMC_FLASH_WD_MS))
          state_next = ST_RESET;
        else if (flash_exit_in)
          state_next = ST_RESET;
        else if (wd_refresh_in)
          refresh = 1'b1;
      end
      ST_LP_ON: begin
        if (vdd_low) begin
          state_next   = ST_RESET;
          rst_len_next = long_rst_sel_in ? `SMC_LONG_RST_MS : `SMC_RST_MS;
        end else if ((|wake_sync) || nreq_wake_cmd_in || oc_wake) begin
          state_next = ST_NREQ;
          lp_wake    = 1'b1;
          nreq_len_next = wd_period(nreq_short_sel_in);
        end else if (lp_wd_refresh_in || oc_brief)
          refresh = 1'b1;
        else if (lp_wd_en_in && !debug_active_out && tmr_reg >= wd_per) begin
          state_next   = ST_RESET;
          rst_len_next = `SMC_RST_MS;
        end
      end
      ST_LP_OFF: begin
        if (|wake_sync) begin
          state_next   = ST_RESET;
          rst_len_next = `SMC_RST_MS;
        end
      end
      default: state_next = ST_INIT_RST;
    endcase
  end

  // Debug is only caught on leaving init reset; command beats the pin level.
  always @* begin
    dbg_next = debug_active_out;
    if (state_reg == ST_INIT_RST && state_next == ST_INIT)
      dbg_next = dbg_lvl;
    if (debug_exit_in || !dbg_lvl)
      dbg_next = 1'b0;
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg            <= ST_INIT_RST;
      tmr_reg              <= 16'h0;
      rst_len_reg          <= `SMC_RST_MS;
      nreq_len_reg         <= `SMC_NREQ_TMO_MS;
      debug_active_out     <= 1'b0;
      supply_loss_flag_out <= 1'b1;
      wake_flags_out       <= 5'h0;
      oc_cnt_reg           <= 16'h0;
      oc_prev_reg          <= 1'b0;
    end else begin
      state_reg        <= state_next;
      rst_len_reg      <= rst_len_next;
      nreq_len_reg     <= nreq_len_next;
      debug_active_out <= dbg_next;
      oc_prev_reg      <= oc_high;
      // A single tick drives every mode timer so prescale scales them all.
      if (st_chg || refresh)
        tmr_reg <= 16'h0;
      else if (tick && tmr_reg != 16'hffff)
        tmr_reg <= tmr_reg + 16'h1;
      if (state_reg != ST_LP_ON || !oc_high)
        oc_cnt_reg <= oc_high ? 16'h0 : (oc_prev_reg ? oc_cnt_reg : 16'h0);
      else if (tick && oc_cnt_reg != 16'hffff)
        oc_cnt_reg <= oc_cnt_reg + 16'h1;
      if (supply_loss_clr_in)
        supply_loss_flag_out <= 1'b0;
      // New wake sources win over a clear in the same cycle.
      if ((state_reg == ST_LP_OFF || state_reg == ST_LP_ON) && (|wake_sync))
        wake_flags_out <= (wake_flag_clr_in ? 5'h0 : wake_flags_out) | wake_sync;
      else if (wake_flag_clr_in)
        wake_flags_out <= 5'h0;
    end
  end

  // Random code for secured commands; a fresh value is shown per request.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lfsr_reg        <= `SMC_LFSR_SEED;
      random_code_out <= 8'h0;
      sec_pend_reg    <= 1'b0;
      sec_tgt_reg     <= 2'h0;
    end else begin
      lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `SMC_LFSR_TAPS) : (lfsr_reg >> 1);
      if (sec_req_in && state_reg == ST_NORMAL) begin
        random_code_out <= lfsr_reg;
        sec_pend_reg    <= 1'b1;
        sec_tgt_reg     <= sec_target_in;
      end else if (sec_confirm_in || st_chg)
        sec_pend_reg <= 1'b0;
    end
  end

  // Supply-on wake-ups always pulse; other events follow the level or pulse choice.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      int_lvl_reg <= 1'b0;
      int_cnt_reg <= 16'h0;
      int_n_out   <= 1'b1;
    end else begin
      if (int_event && !int_pulse_sel_in && !lp_wake)
        int_lvl_reg <= 1'b1;
      else if (int_clr_in)
        int_lvl_reg <= 1'b0;
      if (lp_wake || (int_event && int_pulse_sel_in))
        int_cnt_reg <= {14'h0, int_width_sel_in} + 16'h1;
      else if (tick && int_cnt_reg != 16'h0)
        int_cnt_reg <= int_cnt_reg - 16'h1;
      int_n_out <= !(int_lvl_reg || int_cnt_reg != 16'h0);
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_n_out      <= 1'b0;
      vdd_en_out     <= 1'b1;
      vdd_pnp_en_out <= 1'b0;
      can5v_en_out   <= 1'b0;
      func_en_out    <= 1'b0;
    end else begin
      rst_n_out      <= !(state_next == ST_INIT_RST || state_next == ST_RESET);
      vdd_en_out     <= (state_next != ST_LP_OFF);
      vdd_pnp_en_out <= (state_next == ST_NORMAL || state_next == ST_FLASH);
      func_en_out    <= !(state_next == ST_INIT_RST || state_next == ST_INIT
                          || state_next == ST_LP_ON || state_next == ST_LP_OFF);
      if (state_next == ST_LP_ON || state_next == ST_LP_OFF || state_next == ST_INIT_RST)
        can5v_en_out <= 1'b0;
      else if (state_next == ST_INIT)
        can5v_en_out <= dbg_next;
      else
        can5v_en_out <= can5v_ctl_in || dbg_next;
    end
  end
endmodule

// *** dv/smc_mode_checker.sv ***
// Concurrent checks on the ports of the mode state controller.
`timescale 1ns/1ps
module smc_mode_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire       clk_sys_in,
  input wire       rst_in,
  input wire       wd_refresh_in,
  input wire       init_wr_in,
  input wire       lp_on_req_in,
  input wire       lp_off_req_in,
  input wire       wake_flag_clr_in,
  input wire       sec_confirm_in,
  input wire [7:0] sec_code_in,
  input wire [7:0] mode_out,
  input wire       rst_n_out,
  input wire       init_wr_accept_out,
  input wire       vdd_en_out,
  input wire       vdd_pnp_en_out,
  input wire       can5v_en_out,
  input wire       func_en_out,
  input wire       debug_active_out,
  input wire [4:0] wake_flags_out,
  input wire [7:0] random_code_out
);
  reg [15:0] irst_cnt_reg;
  // A stuck init reset shows as this count running past one tick.
  always @(posedge clk_sys_in) begin
    if (rst_in || mode_out != 8'h01) irst_cnt_reg <= 16'h0000;
    else irst_cnt_reg <= irst_cnt_reg + 16'h0001;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_reset_exit;
    mode_out == 8'h04 ##1 mode_out != 8'h04;
  endsequence
  sequence s_irst_exit;
    mode_out == 8'h01 ##1 mode_out != 8'h01;
  endsequence
  a_pnp_mode_gate: assert property (
    vdd_pnp_en_out |-> mode_out inside {8'h10, 8'h20})
    else $error("pass enable outside normal or flash");
  a_reset_pin_low: assert property (
    rst_n_out == !(mode_out inside {8'h01, 8'h04}))
    else $error("reset pin does not follow the reset states");
  a_init_wr_gate: assert property (
    init_wr_accept_out == (init_wr_in && mode_out == 8'h02))
    else $error("init write accepted outside config");
  a_init_funcs_off: assert property (
    mode_out == 8'h02 && $stable(mode_out) && $stable(debug_active_out)
    |-> !func_en_out && can5v_en_out == debug_active_out)
    else $error("functions or supply wrong in config");
  a_refresh_to_normal: assert property (
    mode_out inside {8'h02, 8'h08} && wd_refresh_in |=> mode_out == 8'h10)
    else $error("refresh did not reach normal");
  a_lp_refused: assert property (
    mode_out == 8'h10 && wake_flags_out != 5'h00 && !wake_flag_clr_in
    && (lp_on_req_in || lp_off_req_in) |=> !(mode_out inside {8'h40, 8'h80}))
    else $error("low power entered with wake flags set");
  a_reset_to_nreq: assert property (
    s_reset_exit |-> mode_out == 8'h08)
    else $error("reset not followed by normal request");
  a_irst_to_init: assert property (
    s_irst_exit |-> mode_out == 8'h02)
    else $error("init reset not followed by config");
  a_sec_code_check: assert property (
    mode_out == 8'h10 && sec_confirm_in && sec_code_in != ~random_code_out
    |=> !(mode_out inside {8'h02, 8'h20}))
    else $error("secured move taken with a wrong code");
  a_irst_length: assert property (
    irst_cnt_reg <= TICK_CYCLES + 2)
    else $error("init reset held past one tick");
  a_lp_off_supplies: assert property (
    mode_out == 8'h80 |-> !vdd_en_out && !can5v_en_out)
    else $error("supplies on in low power supply off");
endmodule
bind smc_mode_ctrl smc_mode_checker #(.TICK_CYCLES(TICK_CYCLES)) smc_mode_checker_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wd_refresh_in(wd_refresh_in),
  .init_wr_in(init_wr_in), .lp_on_req_in(lp_on_req_in), .lp_off_req_in(lp_off_req_in),
  .wake_flag_clr_in(wake_flag_clr_in), .sec_confirm_in(sec_confirm_in),
  .sec_code_in(sec_code_in), .mode_out(mode_out), .rst_n_out(rst_n_out),
  .init_wr_accept_out(init_wr_accept_out), .vdd_en_out(vdd_en_out),
  .vdd_pnp_en_out(vdd_pnp_en_out), .can5v_en_out(can5v_en_out), .func_en_out(func_en_out),
  .debug_active_out(debug_active_out), .wake_flags_out(wake_flags_out),
  .random_code_out(random_code_out));

// *** dv/smc_host_model.sv ***
// Host model that answers a secured request with the inverted returned code, or the plain code while corrupt_in is set.
`timescale 1ns/1ps
module smc_host_model (
  input  wire       clk_sys_in,
  input  wire       sec_req_in,
  input  wire       corrupt_in,
  input  wire [7:0] random_code_in,
  output reg        sec_confirm_out,
  output reg  [7:0] sec_code_out
);
  reg [1:0] wait_reg = 2'h0;
  reg       seen_reg = 1'b0;
  initial sec_confirm_out = 1'b0;
  initial sec_code_out = 8'h00;
  always @(posedge clk_sys_in) seen_reg <= sec_req_in;
  always @(negedge clk_sys_in) begin
    sec_confirm_out <= 1'b0;
    // Idle code lines toggle every cycle, so a stale value still looks valid on every other cycle.
    sec_code_out <= ~sec_code_out;
    if (wait_reg == 2'h1) begin
      sec_confirm_out <= 1'b1;
      sec_code_out <= corrupt_in ? random_code_in : ~random_code_in;
    end
    if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
    if (seen_reg) wait_reg <= 2'h3;
  end
endmodule

// *** dv/smc_mode_ctrl_test.sv ***
// Self-checking bench for the mode state controller.
`timescale 1ns/1ps
module smc_mode_ctrl_test;
  localparam TC = 4;
  // Rows: bit23 hold-and-compare, cmd[19:16], expected mode, wait limit.
  localparam logic [23:0] ROWS [0:24] = '{
    24'h820208, 24'h8c0208, 24'h011004, 24'h8c1008, 24'h871008,
    24'h024004, 24'h040808, 24'h011004, 24'h038004, 24'h0508c8,
    24'h011004, 24'h821008, 24'h8b1004, 24'h024004, 24'h040808,
    24'h011004, 24'h082010, 24'h070864, 24'h011004, 24'h8d1010,
    24'h060864, 24'h011004, 24'h090864, 24'h011004, 24'h0a0210};
  reg clk_sys_in = 1'b0, win = 1'b0;
  reg rst_in = 1'b1;
  reg dbg_lvl = 0, vdd_low = 0, sleep_cur = 0, refresh = 0, wd_bad = 0, init_wr = 0;
  reg lp_off = 0, lp_on = 0, nreq_wake = 0, flash_exit = 0, sec_req = 0, debug_exit = 0;
  reg long_rst = 0, can5v_ctl = 0, int_clr = 0, flag_clr = 0, loss_clr = 0, corrupt = 0;
  reg [4:0] wake_src = 5'h00;
  reg [1:0] wd_sel = 2'h3, sec_tgt = 2'h0, nreq_sel = 2'h3, oc_sel = 2'h0, int_en = 2'h0;
  wire [7:0] mode, rcode, sec_code;
  wire [4:0] wflags;
  wire       rst_n, int_n, accept, vdd_en, pnp_en, can5v_en, func_en, dbg_act, loss, sec_conf;
  integer    bad_count = 0, compares = 0, i, n;
  always #12.5 clk_sys_in = ~clk_sys_in;
  smc_mode_ctrl #(.TICK_CYCLES(TC)) smc_mode_ctrl_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .debug_level_input_in(dbg_lvl),
    .vdd_low_in(vdd_low), .sleep_current_in(sleep_cur), .wake_src_in(wake_src),
    .wd_refresh_in(refresh), .wd_bad_in(wd_bad), .wd_window_in(win),
    .wd_period_sel_in(wd_sel), .init_wr_in(init_wr), .lp_off_req_in(lp_off),
    .lp_on_req_in(lp_on), .nreq_wake_cmd_in(nreq_wake), .lp_wd_refresh_in(1'b0),
    .lp_wd_en_in(1'b0), .flash_exit_in(flash_exit), .sec_req_in(sec_req),
    .sec_target_in(sec_tgt), .sec_confirm_in(sec_conf), .sec_code_in(sec_code),
    .debug_exit_in(debug_exit), .long_rst_sel_in(long_rst), .nreq_short_sel_in(nreq_sel),
    .oc_time_sel_in(oc_sel), .can5v_ctl_in(can5v_ctl), .int_en_in(int_en),
    .int_pulse_sel_in(1'b0), .int_width_sel_in(2'h0), .int_clr_in(int_clr),
    .wake_flag_clr_in(flag_clr), .supply_loss_clr_in(loss_clr), .mode_out(mode),
    .rst_n_out(rst_n), .int_n_out(int_n), .init_wr_accept_out(accept), .vdd_en_out(vdd_en),
    .vdd_pnp_en_out(pnp_en), .can5v_en_out(can5v_en), .func_en_out(func_en),
    .debug_active_out(dbg_act), .supply_loss_flag_out(loss), .wake_flags_out(wflags),
    .random_code_out(rcode));
  smc_host_model smc_host_model_i (.clk_sys_in(clk_sys_in), .sec_req_in(sec_req),
    .corrupt_in(corrupt), .random_code_in(rcode), .sec_confirm_out(sec_conf),
    .sec_code_out(sec_code));
  task chk(input [7:0] seen, input [7:0] exp, input string what);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cmd(input [3:0] c);
    begin
      @(negedge clk_sys_in);
      corrupt = (c == 4'hd);
      sec_tgt = (c == 4'h9) ? 2'h2 : ((c == 4'ha) ? 2'h0 : 2'h1);
      case (c)
        4'h1: refresh = 1'b1;
        4'h2: lp_on = 1'b1;
        4'h3: lp_off = 1'b1;
        4'h4: nreq_wake = 1'b1;
        4'h5: wake_src = 5'h01;
        4'h6: wd_bad = 1'b1;
        4'h7: flash_exit = 1'b1;
        4'h8, 4'h9, 4'ha, 4'hd: sec_req = 1'b1;
        4'hb: flag_clr = 1'b1;
        4'hc: init_wr = 1'b1;
        4'he: loss_clr = 1'b1;
        4'hf: int_clr = 1'b1;
        default: debug_exit = 1'b1;
      endcase
      @(negedge clk_sys_in);
      {refresh, lp_on, lp_off, nreq_wake, wd_bad, flash_exit, sec_req} = 7'h00;
      {flag_clr, init_wr, loss_clr, int_clr, debug_exit} = 5'h00;
      wake_src = 5'h00;
    end
  endtask
  task wait_mode(input [7:0] exp, input integer lim, input fixed);
    integer k;
    begin
      k = 0;
      while (k < lim && (fixed || mode !== exp)) begin
        @(negedge clk_sys_in);
        k = k + 1;
      end
      chk(mode, exp, "mode");
    end
  endtask
  task rst_len(input integer lim, output integer len);
    integer k;
    begin
      k = 0;
      while (k < lim && rst_n !== 1'b0) begin
        @(negedge clk_sys_in);
        k = k + 1;
      end
      vdd_low = 1'b0;
      len = 0;
      while (len < 400 && rst_n === 1'b0) begin
        @(negedge clk_sys_in);
        len = len + 1;
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_in);
    chk(mode, 8'h01, "mode");
    chk({rst_n, int_n, vdd_en, loss}, 8'h07, "reset outputs");
    rst_in = 1'b0;
    wait_mode(8'h02, 4 * TC, 0);
    cmd(4'he);
    chk(loss, 1'b0, "supply loss");
    for (i = 0; i < 25; i = i + 1) begin
      cmd(ROWS[i][19:16]);
      wait_mode(ROWS[i][15:8], ROWS[i][7:0], ROWS[i][23]);
      if (i == 11) chk(wflags, 8'h01, "wake flags");
      if (i == 12) chk(wflags, 8'h00, "wake flags");
    end
    wait_mode(8'h02, 250 * TC, 1);
    wait_mode(8'h01, 20 * TC, 0);
    wait_mode(8'h02, 4 * TC, 0);
    can5v_ctl = 1'b1;
    cmd(4'h1);
    wait_mode(8'h10, 4, 0);
    chk({pnp_en, func_en, can5v_en}, 8'h07, "normal enables");
    long_rst = 1'b1;
    vdd_low = 1'b1;
    rst_len(20, n);
    chk(n >= 9 * TC && n <= 10 * TC + 2, 1'b1, "long reset");
    wait_mode(8'h08, 8, 0);
    cmd(4'h1);
    wd_sel = 2'h0;
    rst_len(20 * TC, n);
    chk(n <= TC + 2, 1'b1, "watchdog reset");
    wait_mode(8'h08, 8, 0);
    wd_sel = 2'h3;
    {nreq_sel, oc_sel, int_en} = 6'h26;
    cmd(4'h1);
    // An early refresh with the window enabled must be punished by a reset.
    win = 1'b1;
    cmd(4'h1);
    wait_mode(8'h08, 8 * TC, 0);
    win = 1'b0;
    cmd(4'h1);
    cmd(4'h2);
    wait_mode(8'h40, 4, 0);
    sleep_cur = 1'b1;
    wait_mode(8'h40, 6 * TC, 1);
    wait_mode(8'h08, 10 * TC, 0);
    sleep_cur = 1'b0;
    // The pin is registered one cycle behind the mode change.
    @(negedge clk_sys_in);
    chk(int_n, 1'b0, "interrupt");
    cmd(4'hf);
    // A one-tick pulse may still stand for up to a tick after the command.
    repeat (TC) @(negedge clk_sys_in);
    chk(int_n, 1'b1, "interrupt");
    dbg_lvl = 1'b1;
    rst_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    wait_mode(8'h02, 4 * TC, 0);
    chk({dbg_act, can5v_en}, 8'h03, "debug supply");
    wait_mode(8'h02, 300 * TC, 1);
    cmd(4'h0);
    chk(dbg_act, 1'b0, "debug");
    wrap_up;
  end
  initial begin
    #(25 * 20000);
    bad_count = bad_count + 1;
    wrap_up;
  end
endmodule
